/* rtl/smp_port_map.vh */
// Register offsets, field positions and reset values of the six-bit port
`ifndef SMP_PORT_MAP_VH
`define SMP_PORT_MAP_VH
`define SMP_ADDR_W          8
`define SMP_OFS_PIN_DATA    8'h05
`define SMP_OFS_DIRECTION   8'h85
`define SMP_OFS_ANALOG_CFG  8'h9f
`define SMP_PORT_W          6
`define SMP_DIR_RESET       6'h3f
`define SMP_DATA_RESET      6'h00
`define SMP_ACFG_W          3
`define SMP_ACFG_RESET      3'h0
`define SMP_ANA_RESET       5'h1f
`define SMP_VREF_RESET      1'h0
`define SMP_BIT_TIMER_CLK   4
`define SMP_BIT_SELECT      5
`define SMP_BIT_REFERENCE   3
`endif

/* rtl/smp_sync2.v */
// Two-flop synchroniser for a vector of pin inputs
`timescale 1ns/100ps
module smp_sync2 #(
  parameter W = 6
) (
  input  wire         i_clock,
  input  wire [W-1:0] i_async,
  output wire [W-1:0] o_sync
);
  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;
  // No reset: the stage only follows the pins, and first stage feeds only the second
  always @(posedge i_clock)
  begin
    meta_q <= i_async;
    sync_q <= meta_q;
  end
  assign o_sync = sync_q;
endmodule // smp_sync2

/* rtl/smp_port.v */
// Six-bit mixed-signal general-purpose port with data, direction and analog configuration registers
// How it works
// R01: Data register holds bits 5..0; bits 7 and 6 read zero, writes ignored.
// R02: Power-on or brown-out clears all data bits; other resets keep bit 4.
// R03: Six-bit direction register, all ones after every kind of reset.
// R04: Pin 4 driver is open drain: pulls low only, never drives high.
// R05: Pin 4 also feeds the first timer's external clock input.
// R06: Pin 5 is general I/O, serial port slave select, or analog input.
// R07: Pins 0..3 are I/O or analog; pin 3 may be converter reference.
// R08: Direction one disables the driver; zero drives the latched data bit.
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/100ps
`include "smp_port_map.vh"
module smp_port #(
  parameter PORT_W = `SMP_PORT_W
) (
  input  wire                   i_clock,
  input  wire                   i_rst_n,
  input  wire                   i_power_reset,
  input  wire [`SMP_ADDR_W-1:0] i_addr,
  input  wire [7:0]             i_wdata,
  input  wire                   i_wr,
  input  wire                   i_rd,
  output reg  [7:0]             o_rdata,
  input  wire [PORT_W-1:0]      i_pin,
  output wire [PORT_W-1:0]      o_pin,
  output wire [PORT_W-1:0]      o_pin_oe_n,
  output wire                   o_first_timer_external_clock,
  output wire                   o_select_n,
  output wire [4:0]             o_analog_channel_enable,
  output wire                   o_reference_enable,
  output wire [`SMP_ACFG_W-1:0] o_analog_config
);
  // ==========================================================
  // Registers, next values and decodes
  reg  [PORT_W-1:0]      data_q;
  reg  [PORT_W-1:0]      data_d;
  reg  [PORT_W-1:0]      dir_q;
  reg  [PORT_W-1:0]      dir_d;
  reg  [`SMP_ACFG_W-1:0] acfg_q;
  reg  [`SMP_ACFG_W-1:0] acfg_d;
  reg  [PORT_W-1:0]      oe_n_q;
  reg  [PORT_W-1:0]      oe_n_d;
  reg  [4:0]             ana_q;
  reg  [4:0]             ana_d;
  reg                    vref_q;
  reg                    vref_d;
  reg  [7:0]             rdata_d;
  wire [PORT_W-1:0]      pin_s;
  wire                   wr_data;
  wire                   wr_dir;
  wire                   wr_acfg;

  // ==========================================================
  // Pin input synchroniser
  // Pins come from outside the clock domain; the two flops cost two
  // cycles of latency on every pin read and on both alternate inputs
  smp_sync2 #(.W(PORT_W)) u_sync (
    .i_clock (i_clock),
    .i_async (i_pin),
    .o_sync  (pin_s)
  );

  // ==========================================================
  // Address decode
  // A write to any unmapped address matches nothing and is ignored
  assign wr_data = i_wr && (i_addr == `SMP_OFS_PIN_DATA);
  assign wr_dir  = i_wr && (i_addr == `SMP_OFS_DIRECTION);
  assign wr_acfg = i_wr && (i_addr == `SMP_OFS_ANALOG_CFG);

  // ==========================================================
  // Next values of the software-visible registers
  // Write bits 7 and 6 have no storage behind them, so they are dropped here
  always @*
  begin
    data_d = data_q;
    dir_d  = dir_q;
    acfg_d = acfg_q;
    if (wr_data)
      data_d = i_wdata[PORT_W-1:0]; // R01
    if (wr_dir)
      dir_d = i_wdata[PORT_W-1:0];  // R03
    if (wr_acfg)
      acfg_d = i_wdata[`SMP_ACFG_W-1:0];
  end

  // Data latch: bit 4 survives resets other than power-on or brown-out
  // Bit 4 stays unknown until the first power-on reset or the first write to the data register
  always @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      data_q[3:0] <= 4'h0; // R02
      data_q[5]   <= 1'h0; // R02
      if (i_power_reset)
        data_q[4] <= 1'h0; // R02
    end
    else
      data_q <= data_d;
  end

  // Direction and analog configuration registers
  always @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      dir_q  <= `SMP_DIR_RESET; // R03
      acfg_q <= `SMP_ACFG_RESET;
    end
    else
    begin
      dir_q  <= dir_d; // R03
      acfg_q <= acfg_d;
    end
  end

  // ==========================================================
  // Register read port
  // The data address returns the synchronised pin levels, not the latch, so
  // a pin held low from outside reads zero even with a one in the latch
  always @*
  begin
    case (i_addr)
      `SMP_OFS_PIN_DATA:   rdata_d = {2'h0, pin_s};  // R01
      `SMP_OFS_DIRECTION:  rdata_d = {2'h0, dir_q};  // R01 R03
      `SMP_OFS_ANALOG_CFG: rdata_d = {5'h00, acfg_q};
      default:             rdata_d = 8'h00;          // R01
    endcase
  end

  // Read data stands for the one cycle after the strobe, zero otherwise
  always @(posedge i_clock)
  begin
    if (!i_rst_n)
      o_rdata <= 8'h00;
    else if (i_rd)
      o_rdata <= rdata_d;
    else
      o_rdata <= 8'h00;
  end

  // ==========================================================
  // Output enables
  // Worked out from next values and registered, so each enable moves in
  // the same cycle as the register behind it and no output is a bare gate
  always @*
  begin
    oe_n_d = dir_d; // R08
    // Open drain: the driver lets go whenever the latched bit is one
    oe_n_d[`SMP_BIT_TIMER_CLK] = dir_d[`SMP_BIT_TIMER_CLK] | data_d[`SMP_BIT_TIMER_CLK]; // R04 R08
  end

  // Every reset leaves all pins as inputs
  always @(posedge i_clock)
  begin
    if (!i_rst_n)
      oe_n_q <= `SMP_DIR_RESET; // R03 R08
    else
      oe_n_q <= oe_n_d;
  end
  assign o_pin_oe_n = oe_n_q;

  // ==========================================================
  // Pin drive levels
  // The open-drain bit never drives high; its level is a constant low
  genvar g;
  generate
    for (g = 0; g < PORT_W; g = g + 1)
    begin : g_drv
      if (g == `SMP_BIT_TIMER_CLK)
      begin : g_od
        assign o_pin[g] = 1'h0; // R04
      end
      else
      begin : g_pp
        assign o_pin[g] = data_q[g]; // R08
      end
    end
  endgenerate

  // ==========================================================
  // Alternate pin functions
  // Both read the synchronised level; the timer sees each pin edge two
  // cycles late and cannot count pulses shorter than a clock period
  assign o_first_timer_external_clock = pin_s[`SMP_BIT_TIMER_CLK]; // R05
  assign o_select_n                   = pin_s[`SMP_BIT_SELECT];    // R06

  // ==========================================================
  // Analog decode
  // Chosen table of the three config bits; decoded from the next value and
  // registered, so the enables follow a write in the very next cycle
  always @*
  begin
    ana_d  = 5'h00;
    vref_d = 1'h0;
    case (acfg_d)
      3'h0:
      begin
        ana_d = 5'h1f; // R06 R07
      end
      3'h1:
      begin
        ana_d  = 5'h17; // R06 R07
        vref_d = 1'h1;  // R07
      end
      3'h2:
      begin
        ana_d = 5'h0f; // R07
      end
      3'h3:
      begin
        ana_d  = 5'h07; // R07
        vref_d = 1'h1;  // R07
      end
      3'h4:
      begin
        ana_d = 5'h03; // R07
      end
      3'h5:
      begin
        ana_d  = 5'h03; // R07
        vref_d = 1'h1;  // R07
      end
      default:
      begin
        // Codes 6 and 7 leave every pin digital
        ana_d  = 5'h00;
        vref_d = 1'h0;
      end
    endcase
  end

  // Registered decode; its reset value is the decode of a cleared config
  always @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      ana_q  <= `SMP_ANA_RESET;
      vref_q <= `SMP_VREF_RESET;
    end
    else
    begin
      ana_q  <= ana_d;
      vref_q <= vref_d;
    end
  end
  assign o_analog_channel_enable = ana_q;  // R06 R07
  assign o_reference_enable      = vref_q; // R07
  assign o_analog_config         = acfg_q;
endmodule // smp_port

/* testbench/smp_port_props.sv */
// Checker of pin, register and decode relations at the port's boundary
`timescale 1ns/100ps
module smp_port_props (
  input wire       i_clock,
  input wire       i_rst_n,
  input wire [7:0] i_addr,
  input wire [7:0] i_wdata,
  input wire       i_wr,
  input wire       i_rd,
  input wire [7:0] o_rdata,
  input wire [5:0] i_pin,
  input wire [5:0] o_pin,
  input wire [5:0] o_pin_oe_n,
  input wire       o_first_timer_external_clock,
  input wire       o_select_n,
  input wire [4:0] o_analog_channel_enable,
  input wire       o_reference_enable
);
  // ==========
  // Properties
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  property p_od; !o_pin_oe_n[4] |-> !o_pin[4]; endproperty
  a_od: assert property (p_od) else $error("pin4 driven high");
  property p_hi; i_rd |=> o_rdata[7:6] == 2'h0; endproperty
  a_hi: assert property (p_hi) else $error("upper bits set");
  property p_rst; $rose(i_rst_n) |-> o_pin_oe_n == 6'h3f && o_pin == 6'h00; endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_dir; i_wr && i_addr == 8'h85 |=> o_pin_oe_n[3:0] == $past(i_wdata[3:0]); endproperty
  a_dir: assert property (p_dir) else $error("enable wrong");
  property p_dat; i_wr && i_addr == 8'h05 |=> o_pin[3:0] == $past(i_wdata[3:0]); endproperty
  a_dat: assert property (p_dat) else $error("pin level wrong");
  property p_clk; o_first_timer_external_clock == $past(i_pin[4], 2); endproperty
  a_clk: assert property (p_clk) else $error("timer clock wrong");
  property p_sel; o_select_n == $past(i_pin[5], 2); endproperty
  a_sel: assert property (p_sel) else $error("select wrong");
  property p_cfg; i_wr && i_addr == 8'h9f && i_wdata[2:0] == 3'h2 |=> o_analog_channel_enable == 5'h0f && !o_reference_enable; endproperty
  a_cfg: assert property (p_cfg) else $error("decode wrong");
  property p_idle; !i_rd |=> o_rdata == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("read data outside its cycle");
endmodule // smp_port_props
bind smp_port smp_port_props i_props (.*);

/* testbench/smp_ext.sv */
// Outside circuitry on the six pins
`timescale 1ns/100ps
module smp_ext (
  input  wire [5:0] i_ext,
  input  wire [5:0] i_drv,
  input  wire [5:0] i_oe_n,
  output wire [5:0] o_level
);
  // Released pins follow the outside level; pin 4 can only pull low
  assign o_level = (i_oe_n & i_ext) | (~i_oe_n & i_drv);
endmodule // smp_ext

/* testbench/tb.sv */
// Self-checking bench of the six-bit port against a register model
`timescale 1ns/100ps
`include "smp_port_map.vh"
module tb;
  reg        i_clock = 0, i_rst_n = 0, i_power_reset = 1, i_wr = 0, i_rd = 0;
  reg  [7:0] i_addr = 8'h00, i_wdata = 8'h00;
  reg  [5:0] ext = 6'h2a;
  wire [7:0] o_rdata;
  wire [5:0] o_pin, oe_n, lvl;
  wire [2:0] cfg;
  wire [4:0] ana;
  wire       tmr, sel, vr;
  integer    err_total = 0, n_compared = 0, seed = 32'h016c, cyc = 0, k, m_dir = 63, m_dat = 0, v, e, lv, ae;
  smp_port i_smp_port (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_power_reset(i_power_reset), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_pin(lvl), .o_pin(o_pin),
    .o_pin_oe_n(oe_n), .o_first_timer_external_clock(tmr), .o_select_n(sel), .o_analog_channel_enable(ana),
    .o_reference_enable(vr), .o_analog_config(cfg));
  smp_ext i_smp_ext (.i_ext(ext), .i_drv(o_pin), .i_oe_n(oe_n), .o_level(lvl));
  // Clock, and a ceiling far above the few hundred cycles needed
  initial
    forever #12.5 i_clock = ~i_clock;
  always @(posedge i_clock)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      err_total = err_total + 1;
      tally_and_finish;
    end
  end
  task chk(input [7:0] s, input [7:0] x);
    begin
      n_compared = n_compared + 1;
      if (s !== x)
      begin
        err_total = err_total + 1;
        $display("FAIL %0t seen %h want %h", $time, s, x);
      end
    end
  endtask
  // One-cycle access; the model follows writes to the direction and data registers only
  task acc(input w, input [7:0] a, input [7:0] d);
    begin
      @(posedge i_clock);
      i_wr <= w;
      i_rd <= !w;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clock);
      i_wr <= 0;
      i_rd <= 0;
      #1;
      if (w && a == `SMP_OFS_DIRECTION)
        m_dir = d & 63;
      if (w && a == `SMP_OFS_PIN_DATA)
        m_dat = d & 63;
      e = m_dir | m_dat & 16;
    end
  endtask
  task tally_and_finish;
    begin
      $display("compared %0d mismatched %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  // ==========
  // Sequence
  initial
  begin
    repeat (16) @(posedge i_clock);
    i_rst_n <= 1;
    acc(0, `SMP_OFS_DIRECTION, 0);
    chk(o_rdata, 8'h3f);
    acc(0, 8'h40, 0);
    chk(o_rdata, 8'h00);
    // Config code walks all eight values; the rest is random
    for (k = 0; k < 24; k = k + 1)
    begin
      v = $random(seed);
      ext <= v[13:8];
      acc(1, `SMP_OFS_DIRECTION, v[7:0]);
      acc(1, `SMP_OFS_PIN_DATA, v[23:16]);
      acc(1, `SMP_OFS_ANALOG_CFG, {v[31:27], k[2:0]});
      case (k % 8)
        0: ae = 31;
        1: ae = 32 + 23;
        2: ae = 15;
        3: ae = 32 + 7;
        4: ae = 3;
        5: ae = 32 + 3;
        default: ae = 0;
      endcase
      chk(oe_n, e);
      chk(o_pin, m_dat & 47);
      chk(cfg, k[2:0]);
      chk({vr, ana}, ae);
      acc(0, `SMP_OFS_DIRECTION, 0);
      chk(o_rdata, m_dir);
      acc(0, `SMP_OFS_ANALOG_CFG, 0);
      chk(o_rdata, k % 8);
      acc(0, `SMP_OFS_PIN_DATA, 0);
      lv = e & ext | ~e & m_dat & 47;
      chk(o_rdata, lv);
      chk(tmr, lv[4]);
      chk(sel, lv[5]);
    end
    // Bit 4 survives only the lesser reset; all else returns to reset values
    for (k = 0; k < 2; k = k + 1)
    begin
      acc(1, `SMP_OFS_DIRECTION, 0);
      acc(1, `SMP_OFS_PIN_DATA, 8'hff);
      @(posedge i_clock);
      i_power_reset <= k;
      i_rst_n <= 0;
      @(posedge i_clock);
      i_rst_n <= 1;
      m_dat = k ? 0 : 16;
      m_dir = 63;
      #1;
      chk(oe_n, 8'h3f);
      acc(0, `SMP_OFS_DIRECTION, 0);
      chk(o_rdata, 8'h3f);
      acc(1, `SMP_OFS_DIRECTION, 0);
      chk(oe_n, e);
      chk(o_pin, m_dat & 47);
      acc(0, `SMP_OFS_ANALOG_CFG, 0);
      chk(o_rdata, 8'h00);
      chk({vr, ana}, 8'h1f);
      acc(0, `SMP_OFS_PIN_DATA, 0);
      chk(o_rdata, e & ext | ~e & m_dat & 47);
    end
    tally_and_finish;
  end
endmodule // tb
